// File: design/sgpio_top.v
/*
  Configuration registers and pad control for three general-purpose pins
  on two ports of a serializer bridge, with link-loss tracking.
  Assumes a single register clock, a plain strobe bus, and link and
  remote pin values arriving asynchronously from the link transport.
*/
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`include "sgpio_regs.vh"

// Functional notes
// - Stored value drives pin in local output mode, and in mode 111 on link loss.
// - Low mode bits 00 give functional input, 10 high impedance.
// - Mode 001 is local output, mode 011 is general input.
// - Mode 101 outputs remote value, holds last value on link loss.
// - Mode 111 outputs remote value, falls back to local bit on loss.
// - Value bit 0 drives low, 1 high; all value bits reset to 0.
// - Offset 0x0d holds pin zero value bit 3, mode 2:0, per port.
// - Offset 14 holds pin one value bit 3, mode 2:0, per port.
// - Offset 14 holds pin two value bit 7, mode 6:4, per port.
// - Link loss is detected and held in a sticky flag.
module sgpio_top #(
  parameter [3:0] REVISION = 4'h1, // Arbitrary value
  parameter NPORT = 2
) (
  input wire clock_in,
  input wire rst_b_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output wire [7:0] rdata_out,
  input wire [1:0] link_up_in,
  input wire [5:0] remote_val_in,
  input wire [5:0] pad_in,
  input wire [5:0] func_out_in,
  output wire [5:0] pad_out,
  output wire [5:0] pad_oe_b_out,
  output wire [5:0] func_in_out,
  output wire [5:0] gp_in_out
);
  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Per port: {val2, mode2, val1, mode1, val0, mode0}
  reg [3:0] cfg0_r [0:1];
  reg [7:0] cfg12_r [0:1];
  reg second_port_select_r;
  reg [1:0] lost_r;
  reg [7:0] rdata_r;
  reg [7:0] rdata_nxt;
  reg [1:0] link_q_r;
  wire [1:0] link_s;
  wire [5:0] rem_s;
  wire [5:0] pad_s;
  wire psel;
  wire clr_req;
  integer i;
  integer j;

  assign psel = second_port_select_r;
  assign clr_req = wr_in && (addr_in == `SGPIO_OFF_CTRL) &&
    wdata_in[`SGPIO_CTRL_CLR_BIT];

  // ----------------------------------------------------------------------
  // Synchronisers for link-side and pad inputs
  // ----------------------------------------------------------------------
  sgpio_sync #(.WIDTH(14)) u_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .async_in({pad_in, remote_val_in, link_up_in}),
    .sync_out({pad_s, rem_s, link_s})
  );

  function sel_hit;
    input [7:0] a;
    input [7:0] off;
    begin
      sel_hit = (a == off);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (i = 0; i < 2; i = i + 1) begin
        cfg0_r[i] <= `SGPIO_FIELD_RST;
        cfg12_r[i] <= 8'h00;
      end
      second_port_select_r <= 1'b0;
    end else if (wr_in) begin
      if (sel_hit(addr_in, `SGPIO_OFF_CFG0))
        // Upper nibble is revision and never stored
        cfg0_r[psel] <= wdata_in[3:0];
      if (sel_hit(addr_in, `SGPIO_OFF_CFG12))
        cfg12_r[psel] <= wdata_in;
      if (sel_hit(addr_in, `SGPIO_OFF_CTRL))
        second_port_select_r <= wdata_in[`SGPIO_CTRL_PSEL_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Link-loss sticky flags
  // ----------------------------------------------------------------------
  // A falling link sets the flag; set beats a same-cycle clear
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link_q_r <= 2'b00;
      lost_r <= 2'b00;
    end else begin
      link_q_r <= link_s;
      for (j = 0; j < 2; j = j + 1) begin
        if (link_q_r[j] && !link_s[j])
          lost_r[j] <= 1'b1;
        else if (clr_req && (psel == j[0]))
          lost_r[j] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always @* begin
    rdata_nxt = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `SGPIO_OFF_CFG0: rdata_nxt = {REVISION, cfg0_r[psel]};
        `SGPIO_OFF_CFG12: rdata_nxt = cfg12_r[psel];
        `SGPIO_OFF_STATUS: begin
          rdata_nxt[`SGPIO_STAT_LOST_BIT] = lost_r[psel];
          rdata_nxt[`SGPIO_STAT_DET_BIT] = link_s[psel];
        end
        `SGPIO_OFF_CTRL: rdata_nxt = {7'h00, second_port_select_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in)
      rdata_r <= 8'h00;
    else
      rdata_r <= rdata_nxt;
  end

  assign rdata_out = rdata_r;

  // ----------------------------------------------------------------------
  // Pin instances: index p*3+n, port p, pin n
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_pin
      wire [2:0] mode_w;
      wire val_w;
      if (g % 3 == 0) begin : g_z
        assign mode_w = cfg0_r[g/3][`SGPIO_LO_MODE_MSB:0];
        assign val_w = cfg0_r[g/3][`SGPIO_LO_VAL_BIT];
      end else if (g % 3 == 1) begin : g_o
        assign mode_w = cfg12_r[g/3][`SGPIO_LO_MODE_MSB:0];
        assign val_w = cfg12_r[g/3][`SGPIO_LO_VAL_BIT];
      end else begin : g_t
        assign mode_w = cfg12_r[g/3][`SGPIO_HI_MODE_MSB:4];
        assign val_w = cfg12_r[g/3][`SGPIO_HI_VAL_BIT];
      end
      sgpio_pin u_pin (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .mode_in(mode_w),
        .local_val_in(val_w),
        .remote_val_in(rem_s[g]),
        .link_up_in(link_s[g/3]),
        .pad_in(pad_s[g]),
        .func_out_in(func_out_in[g]),
        .pad_out(pad_out[g]),
        .pad_oe_b_out(pad_oe_b_out[g]),
        .func_in_out(func_in_out[g]),
        .gp_in_out(gp_in_out[g])
      );
    end
  endgenerate
endmodule // sgpio_top

// File: design/sgpio_regs.vh
/*
  Register offsets, field positions, reset values and mode codes for the
  serializer pin configuration block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SGPIO_REGS_VH
`define SGPIO_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SGPIO_ADDR_W 8
`define SGPIO_OFF_CFG0 8'h0d
`define SGPIO_OFF_CFG12 8'h0e
`define SGPIO_OFF_STATUS 8'h0c
`define SGPIO_OFF_CTRL 8'h04

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SGPIO_LO_VAL_BIT 3
`define SGPIO_LO_MODE_MSB 2
`define SGPIO_HI_VAL_BIT 7
`define SGPIO_HI_MODE_MSB 6
`define SGPIO_REV_MSB 7
`define SGPIO_REV_LSB 4
`define SGPIO_STAT_LOST_BIT 4
`define SGPIO_STAT_DET_BIT 0
`define SGPIO_CTRL_CLR_BIT 5
`define SGPIO_CTRL_PSEL_BIT 0

// ----------------------------------------------------------------------
// Reset values and mode codes
// ----------------------------------------------------------------------
`define SGPIO_FIELD_RST 4'h0
`define SGPIO_MODE_GP_OUT 3'h1
`define SGPIO_MODE_GP_IN 3'h3
`define SGPIO_MODE_RHOLD 3'h5
`define SGPIO_MODE_RDFLT 3'h7
`define SGPIO_LOW2_FUNC 2'h0
`define SGPIO_LOW2_TRI 2'h2

`endif

// File: design/sgpio_sync.v
/*
  Two flip-flop synchroniser for a bundle of asynchronous levels.
  Assumes the inputs change slowly relative to clock_in.
*/
`timescale 1ns/1ns
module sgpio_sync #(
  parameter WIDTH = 1
) (
  input wire clock_in,
  input wire rst_b_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // First stage feeds only the second stage
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule // sgpio_sync

// File: design/sgpio_pin.v
/*
  Mode decoder and pad driver for one general-purpose pin.
  Assumes remote value, link state and pad input are already synchronous.
*/
`timescale 1ns/1ns
`include "sgpio_regs.vh"
module sgpio_pin (
  input wire clock_in,
  input wire rst_b_in,
  input wire [2:0] mode_in,
  input wire local_val_in,
  input wire remote_val_in,
  input wire link_up_in,
  input wire pad_in,
  input wire func_out_in,
  output wire pad_out,
  output wire pad_oe_b_out,
  output wire func_in_out,
  output wire gp_in_out
);
  reg held_r;
  reg drive_r;
  reg oe_b_r;
  reg drive_nxt;
  reg oe_b_nxt;

  // Remote value captured only while the link is up
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      held_r <= 1'b0;
      drive_r <= 1'b0;
      oe_b_r <= 1'b1;
    end else begin
      if (link_up_in)
        held_r <= remote_val_in;
      drive_r <= drive_nxt;
      oe_b_r <= oe_b_nxt;
    end
  end

  always @* begin
    drive_nxt = 1'b0;
    oe_b_nxt = 1'b1;
    if (mode_in[1:0] == `SGPIO_LOW2_FUNC) begin
      // Functional role: func_out_in goes to pad_out but the pad is never enabled
      drive_nxt = func_out_in;
      oe_b_nxt = 1'b1;
    end else if (mode_in[1:0] == `SGPIO_LOW2_TRI) begin
      oe_b_nxt = 1'b1;
    end else begin
      case (mode_in)
        `SGPIO_MODE_GP_OUT: begin
          drive_nxt = local_val_in;
          oe_b_nxt = 1'b0;
        end
        `SGPIO_MODE_GP_IN: begin
          oe_b_nxt = 1'b1;
        end
        `SGPIO_MODE_RHOLD: begin
          drive_nxt = link_up_in ? remote_val_in : held_r;
          oe_b_nxt = 1'b0;
        end
        `SGPIO_MODE_RDFLT: begin
          drive_nxt = link_up_in ? remote_val_in : local_val_in;
          oe_b_nxt = 1'b0;
        end
        default: begin
          oe_b_nxt = 1'b1;
        end
      endcase
    end
  end

  assign pad_out = drive_r;
  assign pad_oe_b_out = oe_b_r;
  assign func_in_out = (mode_in[1:0] == `SGPIO_LOW2_FUNC) ? pad_in : 1'b0;
  assign gp_in_out = pad_in;
endmodule // sgpio_pin

// File: dv/sgpio_top_assertions.sv
/*
  Port checker for the pin configuration block.
  Assumes it is bound to sgpio_top, one clock, reset low active.
*/
`timescale 1ns/1ns
module sgpio_chk #(
  parameter [3:0] REVISION = 4'h1
) (
  input wire clock_in,
  input wire rst_b_in,
  input wire [7:0] addr_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  input wire [5:0] pad_in,
  input wire [5:0] pad_out,
  input wire [5:0] pad_oe_b_out,
  input wire [5:0] func_in_out,
  input wire [5:0] gp_in_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not idle");
  a_rev_field: assert property ($past(rd_in && addr_in == 8'h0d)
    |-> rdata_out[7:4] == REVISION) else $error("bad revision field");
  a_stat_resv: assert property ($past(rd_in && addr_in == 8'h0c)
    |-> rdata_out[7:5] == 3'h0) else $error("status spare bits set");
  a_unmapped_zero: assert property ($past(rd_in && addr_in == 8'h20)
    |-> rdata_out == 8'h00) else $error("unmapped read not zero");
  a_reset_idle: assert property ($rose(rst_b_in)
    |-> pad_oe_b_out == 6'h3f && pad_out == 6'h00)
    else $error("pads not idle after reset");
  a_oe_cause: assert property ($past(rst_b_in) && $changed(pad_oe_b_out)
    |-> $past(wr_in, 2)) else $error("drive enable moved without write");
  a_gp_sync: assert property ($past(rst_b_in) && $past(rst_b_in, 2)
    |-> gp_in_out == $past(pad_in, 2)) else $error("input path wrong");
  a_func_mask: assert property ($past(rst_b_in) && $past(rst_b_in, 2)
    |-> (func_in_out & ~$past(pad_in, 2)) == 6'h00)
    else $error("functional input not gated");
  cover property ($past(rd_in && addr_in == 8'h0d));
  cover property ($fell(pad_oe_b_out[1]));
  cover property (func_in_out != 6'h00);
endmodule // sgpio_chk

// File: dv/sgpio_far_model.sv
/*
  Remote deserializer stand-in: link state and remote pin values.
  Assumes the bench commands each link drop per port.
*/
`timescale 1ns/1ns
module sgpio_far_model (
  input wire clock_in,
  input wire [1:0] drop_in,
  input wire [5:0] val_in,
  output logic [1:0] link_up_out,
  output logic [5:0] remote_val_out
);
  wire [5:0] dm = {{3{drop_in[1]}}, {3{drop_in[0]}}};
  initial begin
    link_up_out = 2'h3;
    remote_val_out = 6'h00;
  end
  // A dropped port carries nothing valid, so its bits toggle every cycle
  always @(posedge clock_in) begin
    link_up_out <= ~drop_in;
    remote_val_out <= (val_in & ~dm) | (~remote_val_out & dm);
  end
endmodule // sgpio_far_model

// File: dv/sgpio_top_tb_top.sv
/*
  Bench for the pin configuration block: bus driver, read scoreboard
  and pad checks. Assumes design, checker and far model compiled first.
*/
`timescale 1ns/1ns
module sgpio_top_tb_top;
  localparam [3:0] REV = 4'h6; // Arbitrary value
  logic clock_in = 1'h0, rst_b_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0;
  logic rd_q = 1'h0, dr;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, d, v;
  logic [5:0] pad_in = 6'h00, rv;
  logic [5:0] fo = 6'h00;
  logic [2:0] m;
  logic [1:0] drop = 2'h0;
  wire [7:0] rdata_out;
  wire [5:0] pad_out, oe_b, func_in_out, gp_in_out, rem;
  wire [1:0] link;
  logic [7:0] q[$];
  int miscompares = 0, tests_run = 0, cyc = 0;
  sgpio_top #(.REVISION(REV)) u_dut (.clock_in(clock_in),
    .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .link_up_in(link), .remote_val_in(rem), .pad_in(pad_in),
    .func_out_in(fo), .pad_out(pad_out), .pad_oe_b_out(oe_b),
    .func_in_out(func_in_out), .gp_in_out(gp_in_out));
  sgpio_far_model u_far (.clock_in(clock_in), .drop_in(drop),
    .val_in(rv), .link_up_out(link), .remote_val_out(rem));
  initial forever #20 clock_in = ~clock_in;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= w;
    wr_in <= 1'h1;
    @(posedge clock_in);
    wr_in <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'h1;
    q.push_back(e);
    @(posedge clock_in);
    rd_in <= 1'h0;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Read data stands one cycle only, so it is taken at the next edge
  always @(posedge clock_in) begin
    if (rd_q) chk(rdata_out, q.pop_front());
    rd_q <= rd_in;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop;
    end
  end
  initial begin
    rv = 6'($urandom(58));
    repeat (8) @(posedge clock_in);
    rst_b_in <= 1'h1;
    rd(8'h0d, {REV, 4'h0});
    rd(8'h0e, 8'h00);
    chk({2'h0, oe_b}, 8'h3f);
    wr(8'h0d, 8'hf9);
    rd(8'h0d, {REV, 4'h9});
    repeat (2) @(posedge clock_in);
    chk({6'h00, oe_b[0], pad_out[0]}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      v = 8'($urandom);
      d = {v[7], m, v[3], m};
      dr = m[0] && m != 3'h3;
      pad_in <= 6'($urandom);
      fo <= 6'($urandom);
      wr(8'h0e, d);
      rd(8'h0e, d);
      repeat (3) @(posedge clock_in);
      chk({4'h0, oe_b[2:1], func_in_out[2:1]}, {4'h0, !dr, !dr,
        m[1:0] == 2'h0 && pad_in[2], m[1:0] == 2'h0 && pad_in[1]});
      chk({2'h0, gp_in_out}, {2'h0, pad_in});
      if (dr) chk({6'h00, pad_out[2:1]},
        {6'h00, m == 3'h1 ? {d[7], d[3]} : rv[2:1]});
    end
    wr(8'h0e, {~rv[2], 3'h7, ~rv[1], 3'h5});
    drop <= 2'h1;
    repeat (6) @(posedge clock_in);
    chk({6'h00, pad_out[2:1]}, {6'h00, ~rv[2], rv[1]});
    rd(8'h0c, 8'h10);
    drop <= 2'h0;
    repeat (5) @(posedge clock_in);
    rd(8'h0c, 8'h11);
    wr(8'h04, 8'h20);
    rd(8'h0c, 8'h01);
    wr(8'h04, 8'h01);
    drop <= 2'h2;
    repeat (6) @(posedge clock_in);
    rd(8'h0c, 8'h10);
    wr(8'h0d, 8'h01);
    rd(8'h0e, 8'h00);
    rd(8'h0d, {REV, 4'h1});
    rd(8'h20, 8'h00);
    repeat (2) @(posedge clock_in);
    chk({5'h00, oe_b[3], pad_out[3], pad_out[0]}, 8'h01);
    report_and_stop;
  end
endmodule // sgpio_top_tb_top
bind sgpio_top sgpio_chk #(.REVISION(REVISION)) u_chk (
  .clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe_b_out(pad_oe_b_out),
  .func_in_out(func_in_out), .gp_in_out(gp_in_out));
